/* File: haec_ctrl.sv */
// Halt, inspection and fault-flag control with APB register access
// Overview of operation
// - Inspection halt waits for the next descheduling point, never mid-instruction.
// - Inspection halt completes within three time slices plus high-priority work.
// - Memory refresh keeps running while halted for either reason.
// - Inspection halt: inputs finish, outputs send buffered bytes, no memory fetch.
// - Reset with inspection request high skips memory configuration and refresh burst.
// - After inspection reset boot on request low: from ROM if ROM boot selected, else await link byte.
// - After inspection, instruction pointer is user base (link) or boot vector (ROM).
// - Workspace pointer is user base for ROM, first free word for link.
// - Stack registers hold halt pointer, halt descriptor and booting link number.
// - Fault pin is internal fault flag ORed with chained fault input.
// - Fault flag set by overflow, divide by zero, bounds, software or FPU.
// - Chained fault input affects only the fault pin.
// - Fault flag rising while stop-on-fault set halts every process.
// - Setting stop-on-fault with fault already set does not halt.
// - Flags saved on pre-emption, passed on, restored when high priority ends.
// - Fault halt lets links finish outstanding transfers before shutdown.
// - Fault halt pointer two past instruction, inspection one past; copied to A.
// - Internal memory 80000000 to 80000FFF, user base 80000070 above reserved words.
// - Byte addressed memory, words four-byte aligned, low byte at low address.
// - Configuration data from 7FFFFF6C upward, ROM boot code at 7FFFFFFE.
// - ROM boot fetches from top two bytes of memory at low priority.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module haec_ctrl
  import haec_pkg::*;
#(
  parameter int APB_AW = 8
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              inspect_req,
  input  wire logic              rom_boot_select,
  input  wire logic              fault_chain_in,
  output logic                   fault_out,
  input  wire logic              cfg_done,
  input  wire logic              link_boot_done,
  input  wire logic [1:0]        link_boot_id,
  input  wire logic              links_idle,
  input  wire logic              desched_point,
  input  wire logic              slice_tick,
  input  wire logic              hi_prio_active,
  input  wire logic              preempt_start,
  input  wire logic              preempt_end,
  input  wire logic              overflow_evt,
  input  wire logic              div_zero_evt,
  input  wire logic              bound_evt,
  input  wire logic              fpu_fault_evt,
  input  wire logic [31:0]       fault_instr_addr,
  input  wire logic [31:0]       cur_iptr,
  input  wire logic [31:0]       cur_wdesc,
  input  wire logic [31:0]       mem_addr,
  output logic                   run_en,
  output logic                   out_fetch_en,
  output logic                   refresh_en,
  output logic                   skip_mem_cfg,
  output logic                   boot_go,
  output logic                   boot_low_prio,
  output logic                   halted,
  output logic                   addr_internal,
  output logic                   addr_user,
  output logic                   addr_cfg,
  output logic      [31:0]       addr_word
);

  typedef struct packed {
    haec_state_t st;
    logic        fault;
    logic        stop;
    logic        sv_fault;
    logic        sv_stop;
    logic [1:0]  slice_cnt;
    logic [31:0] halt_iptr;
    logic [31:0] halt_wdesc;
    logic [31:0] boot_iptr;
    logic [31:0] boot_wptr;
    logic [1:0]  boot_link;
    logic [31:0] load_end;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fault_out;
    logic        run_en;
    logic        out_fetch;
    logic        refresh;
    logic        skip_cfg;
    logic        boot_go;
    logic        halted;
    logic        addr_int;
    logic        addr_user;
    logic        addr_cfg;
    logic [31:0] addr_word;
  } haec_regs_t;

  haec_regs_t s_q;
  haec_regs_t s_d;

  logic        setup_ph;
  logic        wr_acc;
  logic        wr_ctrl;
  logic        fault_evt;
  logic        boot_ready;
  logic [31:0] status_w;
  logic [7:0]  reg_ofs;

  always_comb begin
    s_d        = s_q;
    reg_ofs    = 8'(paddr);
    setup_ph   = psel && !penable;
    // A write lands only on the edge where the master sees pready high
    wr_acc     = psel && penable && s_q.pready && pwrite;
    wr_ctrl    = wr_acc && (reg_ofs == HAEC_CTRL_OFS);
    boot_ready = 1'b0;
    status_w   = {s_q.st, 16'h0, s_q.halted, s_q.run_en, s_q.skip_cfg,
                  s_q.sv_stop, s_q.sv_fault, s_q.stop, s_q.fault, 1'b0};
    fault_evt  = overflow_evt || div_zero_evt || bound_evt || fpu_fault_evt ||
                 (wr_ctrl && pwdata[HAEC_CTRL_FSET_BIT]);

    s_d.boot_go = 1'b0;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;

    // Zero-wait-state APB slave: decode in setup, answer in access phase
    if (setup_ph) begin
      s_d.pready = 1'b1;
      case (reg_ofs)
        HAEC_CTRL_OFS:       s_d.prdata = 32'h0;
        HAEC_STATUS_OFS:     s_d.prdata = status_w;
        HAEC_HALT_IPTR_OFS:  s_d.prdata = s_q.halt_iptr;
        HAEC_HALT_WDESC_OFS: s_d.prdata = s_q.halt_wdesc;
        HAEC_BOOT_IPTR_OFS:  s_d.prdata = s_q.boot_iptr;
        HAEC_BOOT_WPTR_OFS:  s_d.prdata = s_q.boot_wptr;
        HAEC_BOOT_LINK_OFS:  s_d.prdata = {30'h0, s_q.boot_link};
        HAEC_LOAD_END_OFS:   s_d.prdata = s_q.load_end;
        default: begin
          s_d.prdata  = 32'h0;
          s_d.pslverr = 1'b1;
        end
      endcase
    end

    if (wr_acc && reg_ofs == HAEC_LOAD_END_OFS) begin
      s_d.load_end = pwdata & HAEC_WORD_MASK;
    end

    // save on pre-emption, restore at the end
    if (preempt_start) begin
      s_d.sv_fault = s_q.fault;
      s_d.sv_stop  = s_q.stop;
    end else if (preempt_end) begin
      s_d.fault = s_q.sv_fault;
      s_d.stop  = s_q.sv_stop;
    end

    if (wr_ctrl && pwdata[HAEC_CTRL_SCLR_BIT]) begin
      s_d.stop = 1'b0;
    end
    if (wr_ctrl && pwdata[HAEC_CTRL_SSET_BIT]) begin
      s_d.stop = 1'b1;
    end
    if (wr_ctrl && pwdata[HAEC_CTRL_FCLR_BIT]) begin
      s_d.fault = 1'b0;
    end
    // Set wins over any clear or restore in the same cycle
    if (fault_evt) begin
      s_d.fault = 1'b1;
    end

    // fault pin; chained input touches nothing else
    s_d.fault_out = s_d.fault || fault_chain_in;

    s_d.addr_int  = (mem_addr >= HAEC_INT_BASE) && (mem_addr <= HAEC_INT_TOP);
    s_d.addr_user = (mem_addr >= HAEC_USER_BASE) && (mem_addr <= HAEC_INT_TOP);
    s_d.addr_cfg  = (mem_addr >= HAEC_CFG_BASE) && (mem_addr < HAEC_INT_BASE);
    // byte address to aligned word address
    s_d.addr_word = mem_addr & HAEC_WORD_MASK;

    // refresh keeps running in every state after reset
    s_d.refresh = 1'b1;

    case (s_q.st)
      HAEC_ST_INIT: begin
        // request level caught at the first edge after reset release
        s_d.skip_cfg = inspect_req;
        s_d.st       = inspect_req ? HAEC_ST_BOOT_INSP : HAEC_ST_BOOT_CFG;
      end
      HAEC_ST_BOOT_CFG: begin
        boot_ready = cfg_done;
      end
      HAEC_ST_BOOT_INSP: begin
        // boot waits for the request to fall
        boot_ready = !inspect_req;
      end
      HAEC_ST_BOOT_LINK: begin
        if (link_boot_done) begin
          // link boot starts at user base
          s_d.boot_iptr = HAEC_USER_BASE;
          s_d.boot_wptr = s_q.load_end;
          s_d.boot_link = link_boot_id;
          s_d.boot_go   = 1'b1;
          s_d.run_en    = 1'b1;
          s_d.out_fetch = 1'b1;
          s_d.st        = HAEC_ST_RUN;
        end
      end
      HAEC_ST_RUN: begin
        // halt on a rising fault with stop armed; needs a fresh rise
        if (fault_evt && !s_q.fault && s_q.stop) begin
          s_d.run_en     = 1'b0;
          // two bytes past the faulting instruction
          s_d.halt_iptr  = fault_instr_addr + HAEC_FAULT_IP_OFS;
          s_d.halt_wdesc = cur_wdesc;
          s_d.st         = HAEC_ST_PEND_FLT;
        end else if (inspect_req) begin
          // stop further output fetches at once
          s_d.out_fetch = 1'b0;
          s_d.slice_cnt = 2'h0;
          s_d.st        = HAEC_ST_PEND_INSP;
        end
      end
      HAEC_ST_PEND_INSP: begin
        // or force it on the third low-priority slice
        if (desched_point ||
            (slice_tick && !hi_prio_active && s_q.slice_cnt == HAEC_SLICE_LIMIT - 2'h1)) begin
          s_d.run_en     = 1'b0;
          s_d.halted     = 1'b1;
          // one byte past the current instruction
          s_d.halt_iptr  = cur_iptr + HAEC_INSP_IP_OFS;
          s_d.halt_wdesc = cur_wdesc;
          s_d.st         = HAEC_ST_HALTED;
        end else if (slice_tick && !hi_prio_active) begin
          s_d.slice_cnt = s_q.slice_cnt + 2'h1;
        end
      end
      HAEC_ST_PEND_FLT: begin
        // links drain before fetches are shut off
        if (links_idle) begin
          s_d.out_fetch = 1'b0;
          s_d.halted    = 1'b1;
          s_d.st        = HAEC_ST_HALTED;
        end
      end
      HAEC_ST_HALTED: begin
        // only reset leaves this state; rely on the controller
        s_d.run_en    = 1'b0;
        s_d.out_fetch = 1'b0;
      end
      default: begin
        s_d.st = HAEC_ST_INIT;
      end
    endcase

    if (boot_ready) begin
      if (rom_boot_select) begin
        // ROM boot from the top two bytes, low priority
        s_d.boot_iptr = HAEC_BOOT_VEC;
        s_d.boot_wptr = HAEC_USER_BASE;
        s_d.boot_go   = 1'b1;
        s_d.run_en    = 1'b1;
        s_d.out_fetch = 1'b1;
        s_d.st        = HAEC_ST_RUN;
      end else begin
        s_d.st = HAEC_ST_BOOT_LINK;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q          <= '0;
      s_q.st       <= HAEC_ST_INIT;
      s_q.load_end <= HAEC_LOAD_END_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign prdata        = s_q.prdata;
  assign pready        = s_q.pready;
  assign pslverr       = s_q.pslverr;
  assign fault_out     = s_q.fault_out;
  assign run_en        = s_q.run_en;
  assign out_fetch_en  = s_q.out_fetch;
  assign refresh_en    = s_q.refresh;
  assign skip_mem_cfg  = s_q.skip_cfg;
  assign boot_go       = s_q.boot_go;
  // Every boot enters at low priority
  assign boot_low_prio = s_q.boot_go;
  assign halted        = s_q.halted;
  assign addr_internal = s_q.addr_int;
  assign addr_user     = s_q.addr_user;
  assign addr_cfg      = s_q.addr_cfg;
  assign addr_word     = s_q.addr_word;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  fault_pin_or_a: assert property (
    clk_en |=> fault_out == ($past(s_d.fault) || $past(fault_chain_in)))
    else $error("fault pin not OR of flag and chain");

  halt_stays_a: assert property (
    halted |=> halted && !run_en)
    else $error("left halted state without reset");

  refresh_halt_a: assert property (
    halted |-> refresh_en)
    else $error("refresh stopped while halted");

  insp_no_fetch_a: assert property (
    s_q.st == HAEC_ST_PEND_INSP |-> !out_fetch_en && run_en)
    else $error("fetch enabled during inspection drain");

  late_stop_a: assert property (
    (s_q.st == HAEC_ST_RUN && s_q.fault && !fault_evt && !inspect_req && clk_en)
      |=> s_q.st == HAEC_ST_RUN)
    else $error("halt without fresh fault rise");

  fault_halt_ip_a: assert property (
    (s_q.st == HAEC_ST_RUN && fault_evt && !s_q.fault && s_q.stop && clk_en)
      |=> s_q.halt_iptr == $past(fault_instr_addr) + HAEC_FAULT_IP_OFS && !run_en)
    else $error("fault halt pointer wrong");

  rom_boot_vec_a: assert property (
    (boot_go && $past(rom_boot_select))
      |-> s_q.boot_iptr == HAEC_BOOT_VEC && s_q.boot_wptr == HAEC_USER_BASE)
    else $error("ROM boot pointers wrong");

  insp_skip_cfg_a: assert property (
    (rstn && s_q.st == HAEC_ST_INIT && clk_en) |=> skip_mem_cfg == $past(inspect_req))
    else $error("configuration skip not caught at reset");

  preempt_restore_a: assert property (
    (preempt_end && !preempt_start && !fault_evt && !wr_ctrl && clk_en)
      |=> s_q.fault == $past(s_q.sv_fault) && s_q.stop == $past(s_q.sv_stop))
    else $error("flags not restored after pre-emption");

  desched_halt_a: assert property (
    (s_q.st == HAEC_ST_PEND_INSP && desched_point && clk_en)
      |=> halted && s_q.halt_iptr == $past(cur_iptr) + HAEC_INSP_IP_OFS)
    else $error("inspection halt missed descheduling point");

  slice_bound_a: assert property (
    s_q.st == HAEC_ST_PEND_INSP |-> s_q.slice_cnt < HAEC_SLICE_LIMIT)
    else $error("inspection slice count overran");

  // The chained input must never reach the internal flag
  chain_no_state_a: assert property (
    (clk_en && !fault_evt && !preempt_end && !wr_ctrl) |=> s_q.fault == $past(s_q.fault))
    else $error("fault flag moved without a cause");

  insp_halt_c: cover property (s_q.st == HAEC_ST_PEND_INSP ##[1:20] halted);
  fault_halt_c: cover property (s_q.st == HAEC_ST_PEND_FLT ##[1:20] halted);
  link_boot_c: cover property (s_q.st == HAEC_ST_BOOT_LINK ##[1:50] boot_go);
  insp_rom_boot_c: cover property (skip_mem_cfg && boot_go);
  slice_halt_c: cover property (s_q.st == HAEC_ST_PEND_INSP && slice_tick ##1 halted);

endmodule // haec_ctrl

/* File: haec_host_model.sv */
// Host model driving the inspection, boot-source and chained fault pins
`timescale 1ns/1ps
module haec_host_model (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic want_insp,
  input  wire logic want_rom,
  input  wire logic want_chain,
  output logic      inspect_req,
  output logic      rom_boot_select,
  output logic      fault_chain_in
);
  logic seen_q;
  initial begin
    {inspect_req, rom_boot_select, fault_chain_in, seen_q} = '0;
  end
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      seen_q <= inspect_req;
    end else begin
      rom_boot_select <= want_rom;
      fault_chain_in  <= want_chain;
      if (want_insp) begin
        inspect_req <= 1'b1;
      end else if (seen_q) begin
        inspect_req <= 1'b0;
        seen_q      <= 1'b0;
      end
    end
  end
endmodule // haec_host_model

/* File: haec_pkg.sv */
// Constants and types for the halt, inspection and fault control block
package haec_pkg;

  // Internal memory map and boot addresses
  localparam logic [31:0] HAEC_INT_BASE  = 32'h8000_0000;
  localparam logic [31:0] HAEC_INT_TOP   = 32'h8000_0fff;
  localparam logic [31:0] HAEC_USER_BASE = 32'h8000_0070;
  localparam logic [31:0] HAEC_CFG_BASE  = 32'h7fff_ff6c;
  localparam logic [31:0] HAEC_BOOT_VEC  = 32'h7fff_fffe;
  localparam logic [31:0] HAEC_WORD_MASK = 32'hffff_fffc;

  // Instruction pointer offsets left at a halt
  localparam logic [31:0] HAEC_FAULT_IP_OFS = 32'h0000_0002;
  localparam logic [31:0] HAEC_INSP_IP_OFS  = 32'h0000_0001;

  // Time slices allowed before an inspection halt is forced
  localparam logic [1:0]  HAEC_SLICE_LIMIT = 2'h3;

  // Register byte offsets
  localparam logic [7:0]  HAEC_CTRL_OFS       = 8'h00;
  localparam logic [7:0]  HAEC_STATUS_OFS     = 8'h04;
  localparam logic [7:0]  HAEC_HALT_IPTR_OFS  = 8'h08;
  localparam logic [7:0]  HAEC_HALT_WDESC_OFS = 8'h0c;
  localparam logic [7:0]  HAEC_BOOT_IPTR_OFS  = 8'h10;
  localparam logic [7:0]  HAEC_BOOT_WPTR_OFS  = 8'h14;
  localparam logic [7:0]  HAEC_BOOT_LINK_OFS  = 8'h18;
  localparam logic [7:0]  HAEC_LOAD_END_OFS   = 8'h1c;

  // Control register bit positions (write one to act)
  localparam int HAEC_CTRL_FSET_BIT = 0;
  localparam int HAEC_CTRL_SSET_BIT = 1;
  localparam int HAEC_CTRL_SCLR_BIT = 2;
  localparam int HAEC_CTRL_FCLR_BIT = 3;

  // Reset value of the loaded-code end register
  localparam logic [31:0] HAEC_LOAD_END_RST = 32'h8000_0070;

  typedef enum logic [7:0] {
    HAEC_ST_INIT      = 8'h01,
    HAEC_ST_BOOT_CFG  = 8'h02,
    HAEC_ST_BOOT_INSP = 8'h04,
    HAEC_ST_BOOT_LINK = 8'h08,
    HAEC_ST_RUN       = 8'h10,
    HAEC_ST_PEND_INSP = 8'h20,
    HAEC_ST_PEND_FLT  = 8'h40,
    HAEC_ST_HALTED    = 8'h80
  } haec_state_t;

endpackage

/* File: halt_analyse_error_control_tb.sv */
// Self-checking bench for the halt, inspection and fault control block
`timescale 1ns/1ps
module halt_analyse_error_control_tb import haec_pkg::*;;
  localparam logic [31:0] FSET = 32'h1 << HAEC_CTRL_FSET_BIT;
  localparam logic [31:0] SSET = 32'h1 << HAEC_CTRL_SSET_BIT;
  localparam logic [31:0] FCLR = 32'h1 << HAEC_CTRL_FCLR_BIT;
  logic        clock, rstn, clk_en, psel, penable, pwrite, cfg_done, link_boot_done;
  logic        links_idle, desched_point, slice_tick, hi_prio_active, preempt_start;
  logic        preempt_end, overflow_evt, div_zero_evt, bound_evt, fpu_fault_evt;
  logic        want_insp, want_rom, want_chain, inspect_req, rom_boot_select;
  logic        fault_chain_in, pready, pslverr, fault_out, run_en, out_fetch_en;
  logic        refresh_en, skip_mem_cfg, boot_go, boot_low_prio, halted, b, err;
  logic        addr_internal, addr_user, addr_cfg;
  logic [1:0]  link_boot_id, id;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, fault_instr_addr, cur_iptr, cur_wdesc, mem_addr;
  logic [31:0] addr_word, rd, a, v, w;
  logic [31:0] addrs[$];
  int          bad_count = 0;
  int          checked = 0;
  int          cyc = 0;

  haec_host_model u_host (.clock, .rstn, .want_insp, .want_rom, .want_chain,
    .inspect_req, .rom_boot_select, .fault_chain_in);
  haec_ctrl u_dut (.clock, .rstn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .inspect_req, .rom_boot_select, .fault_chain_in,
    .fault_out, .cfg_done, .link_boot_done, .link_boot_id, .links_idle, .desched_point,
    .slice_tick, .hi_prio_active, .preempt_start, .preempt_end, .overflow_evt,
    .div_zero_evt, .bound_evt, .fpu_fault_evt, .fault_instr_addr, .cur_iptr, .cur_wdesc,
    .mem_addr, .run_en, .out_fetch_en, .refresh_en, .skip_mem_cfg, .boot_go,
    .boot_low_prio, .halted, .addr_internal, .addr_user, .addr_cfg, .addr_word);

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Hang guard well above the few hundred cycles the sequence needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      summarize();
    end
  end

  task summarize;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Request held until pready is seen high at a rising edge
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [7:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    chk(rd, e);
  endtask
  task stat;
    apb(1'b0, HAEC_STATUS_OFS, 32'h0);
  endtask
  // One-cycle pulse on a selected event input
  task ev(input int k);
    @(posedge clock);
    case (k)
      0: overflow_evt <= 1'b1;
      1: div_zero_evt <= 1'b1;
      2: bound_evt <= 1'b1;
      3: fpu_fault_evt <= 1'b1;
      5: desched_point <= 1'b1;
      6: slice_tick <= 1'b1;
      7: preempt_start <= 1'b1;
      8: preempt_end <= 1'b1;
      9: cfg_done <= 1'b1;
      default: link_boot_done <= 1'b1;
    endcase
    @(posedge clock);
    {overflow_evt, div_zero_evt, bound_evt, fpu_fault_evt, desched_point} <= '0;
    {slice_tick, preempt_start, preempt_end, cfg_done, link_boot_done} <= '0;
  endtask
  // Bounded wait on boot_go (0) or halted (1); checks start at the current edge
  task waitfor(input int k);
    repeat (10) begin
      #1;
      if ((k == 0 && boot_go === 1'b1) || (k == 1 && halted === 1'b1)) break;
      @(posedge clock);
    end
  endtask
  task do_reset;
    @(posedge clock);
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, link_boot_id, mem_addr} = '0;
    {cfg_done, link_boot_done, links_idle, desched_point, slice_tick} = '0;
    {hi_prio_active, preempt_start, preempt_end, overflow_evt, div_zero_evt} = '0;
    {bound_evt, fpu_fault_evt, want_insp, want_rom, want_chain} = '0;
    {fault_instr_addr, cur_iptr, cur_wdesc} = '0;
    clk_en = 1'b1;
    want_rom = 1'b1;
    void'($urandom(48473));
    repeat (3) @(posedge clock);
    chk({refresh_en, run_en, halted, boot_go}, 32'h0);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk({refresh_en, skip_mem_cfg}, 32'h2);
    ev(9);
    waitfor(0);
    chk({boot_go, boot_low_prio, run_en}, 32'h7);
    rdchk(HAEC_BOOT_IPTR_OFS, HAEC_BOOT_VEC);
    rdchk(HAEC_BOOT_WPTR_OFS, HAEC_USER_BASE);
    addrs = {HAEC_INT_BASE, HAEC_INT_TOP, HAEC_INT_TOP + 1, HAEC_USER_BASE - 4,
             HAEC_USER_BASE, HAEC_CFG_BASE - 1, HAEC_BOOT_VEC + 1, $urandom};
    foreach (addrs[i]) begin
      @(posedge clock);
      mem_addr <= addrs[i];
      @(posedge clock);
      #1 a = addrs[i];
      chk({addr_internal, addr_user}, {a >= HAEC_INT_BASE && a <= HAEC_INT_TOP,
          a >= HAEC_USER_BASE && a <= HAEC_INT_TOP});
      chk(addr_cfg, a >= HAEC_CFG_BASE && a <= 32'h7fff_ffff);
      chk(addr_word, a & HAEC_WORD_MASK);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    repeat (4) begin
      b = 1'($urandom);
      @(posedge clock);
      want_chain <= b;
      repeat (3) @(posedge clock);
      #1 chk(fault_out, b);
      stat();
      chk(rd[1], 0);
      want_chain <= 1'b0;
    end
    for (int k = 0; k < 5; k++) begin
      if (k < 4) ev(k);
      else apb(1'b1, HAEC_CTRL_OFS, FSET);
      repeat (2) @(posedge clock);
      #1 chk(fault_out, 1);
      stat();
      chk(rd[2:1], 32'h1);
      apb(1'b1, HAEC_CTRL_OFS, FCLR);
    end
    ev(7);
    apb(1'b1, HAEC_CTRL_OFS, FSET);
    stat();
    chk(rd[1], 1);
    ev(8);
    stat();
    chk(rd[2:1], 32'h0);
    apb(1'b1, HAEC_CTRL_OFS, FSET);
    apb(1'b1, HAEC_CTRL_OFS, SSET);
    repeat (4) @(posedge clock);
    #1 chk({halted, run_en}, 32'h1);
    apb(1'b1, HAEC_CTRL_OFS, FCLR);
    v = $urandom;
    fault_instr_addr <= v;
    ev(0);
    #1 chk(run_en, 0);
    repeat (3) @(posedge clock);
    #1 chk(halted, 0);
    @(posedge clock);
    links_idle <= 1'b1;
    waitfor(1);
    chk(halted, 1);
    ev(5);
    ev(9);
    #1 chk({halted, run_en, boot_go, refresh_en}, 32'h9);
    rdchk(HAEC_HALT_IPTR_OFS, v + HAEC_FAULT_IP_OFS);
    // Reset only once halted with links quiet
    do_reset();
    ev(9);
    waitfor(0);
    v = $urandom;
    w = $urandom;
    @(posedge clock);
    cur_iptr <= v;
    cur_wdesc <= w;
    want_insp <= 1'b1;
    repeat (6) @(posedge clock);
    #1 chk({halted, out_fetch_en, refresh_en}, 32'h1);
    ev(5);
    waitfor(1);
    chk({halted, refresh_en}, 32'h3);
    rdchk(HAEC_HALT_IPTR_OFS, v + HAEC_INSP_IP_OFS);
    rdchk(HAEC_HALT_WDESC_OFS, w);
    want_rom <= 1'b1;
    do_reset();
    #1 chk({skip_mem_cfg, boot_go}, 32'h2);
    @(posedge clock);
    want_insp <= 1'b0;
    waitfor(0);
    chk(boot_go, 1);
    rdchk(HAEC_BOOT_IPTR_OFS, HAEC_BOOT_VEC);
    rdchk(HAEC_BOOT_WPTR_OFS, HAEC_USER_BASE);
    want_insp <= 1'b1;
    hi_prio_active <= 1'b1;
    repeat (4) @(posedge clock);
    ev(6);
    hi_prio_active <= 1'b0;
    ev(6);
    ev(6);
    repeat (2) @(posedge clock);
    #1 chk(halted, 0);
    ev(6);
    waitfor(1);
    chk(halted, 1);
    @(posedge clock);
    want_rom <= 1'b0;
    do_reset();
    want_insp <= 1'b0;
    v = $urandom;
    apb(1'b1, HAEC_LOAD_END_OFS, v);
    rdchk(HAEC_LOAD_END_OFS, v & HAEC_WORD_MASK);
    id = 2'($urandom);
    link_boot_id <= id;
    ev(10);
    waitfor(0);
    chk(boot_go, 1);
    rdchk(HAEC_BOOT_IPTR_OFS, HAEC_USER_BASE);
    rdchk(HAEC_BOOT_WPTR_OFS, v & HAEC_WORD_MASK);
    rdchk(HAEC_BOOT_LINK_OFS, {30'h0, id});
    summarize();
  end
endmodule // halt_analyse_error_control_tb
